// file: logic/cio_pkg.sv
// Purpose: constants and types for the contact io configuration store
// Assumes: single clock, settings written one item at a time
// Notes: item codes select which setting a write request targets
package cio_pkg;

  typedef enum logic [1:0] {
    CIO_LOCAL_MODE = 2'h0,
    CIO_DISCRETE_CONTACT_MODE = 2'h1,
    CIO_SERIAL_MODE = 2'h2
  } cio_mode_type;

  typedef enum logic [2:0] {
    CIO_IN_OFF = 3'h0,
    CIO_IN_RUN_STOP = 3'h1,
    CIO_IN_EXT_SWITCH_NORMALLY_OPEN = 3'h2,
    CIO_IN_EXT_SWITCH_NORMALLY_CLOSED = 3'h3,
    CIO_IN_REMOTE = 3'h4
  } cio_in_func_type;

  // output functions, codes 0..14
  localparam logic [3:0] CIO_OUT_OFF = 4'h0;
  localparam logic [3:0] CIO_OUT_RUN = 4'h1;
  localparam logic [3:0] CIO_OUT_REMOTE_STATE = 4'h2;
  localparam logic [3:0] CIO_OUT_ALARM_STATE = 4'h6;
  localparam logic [3:0] CIO_OUT_SELECTED_ALARM = 4'h7;
  localparam logic [3:0] CIO_OUT_FUNC_MAX = 4'hE;

  // item codes of a write request
  localparam logic [3:0] CIO_ITEM_MODE = 4'h0;
  localparam logic [3:0] CIO_ITEM_IN_FUNC = 4'h1;
  localparam logic [3:0] CIO_ITEM_IN_TYPE = 4'h2;
  localparam logic [3:0] CIO_ITEM_IN_DELAY = 4'h3;
  localparam logic [3:0] CIO_ITEM_IN_OFFDET = 4'h4;
  localparam logic [3:0] CIO_ITEM_OUT_FUNC = 4'h5;
  localparam logic [3:0] CIO_ITEM_OUT_POL = 4'h6;
  localparam logic [3:0] CIO_ITEM_OUT_ALARM = 4'h7;

  // reset values, type and polarity codes, delay and off-detect limits
  localparam logic [1:0] CIO_MODE_RESET = 2'h0;
  localparam logic [2:0] CIO_IN1_FUNC_RESET = 3'h1;
  localparam logic [2:0] CIO_IN2_FUNC_RESET = 3'h0;
  localparam logic CIO_TYPE_ALTERNATE = 1'h0;
  localparam logic CIO_TYPE_MOMENTARY = 1'h1;
  localparam logic CIO_POL_A = 1'h0;
  localparam logic CIO_POL_B = 1'h1;
  localparam logic [2:0] CIO_POL_RESET = 3'h4;
  localparam logic [11:0] CIO_OUT_FUNC_RESET = 12'h621;
  localparam logic [6:0] CIO_ALARM_RESET = 7'h01;
  localparam logic [8:0] CIO_DELAY_RESET = 9'h000;
  localparam logic [3:0] CIO_OFFDET_RESET = 4'h0;
  localparam logic [8:0] CIO_DELAY_MAX = 9'h12C;
  localparam logic [3:0] CIO_OFFDET_MAX = 4'hA;

endpackage : cio_pkg

// file: logic/cio_out_drive.sv
// Purpose: drives one contact output from its status and polarity
// Assumes: status inputs are on clk_in
// Notes: polarity A closes on active, B opens on active
`timescale 1ns/10ps
module cio_out_drive
  import cio_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] func_in,
  input wire logic polarity_in,
  input wire logic [6:0] alarm_sel_in,
  input wire logic [14:0] status_in,
  input wire logic [6:0] alarm_active_in,
  output logic closed_out
);
  wire logic active;
  wire logic sel_match;
  wire logic raw;

  assign sel_match = (alarm_active_in == alarm_sel_in);
  assign active = (func_in == CIO_OUT_SELECTED_ALARM) ? sel_match :
    status_in[func_in];
  assign raw = (func_in == CIO_OUT_OFF) ? 1'b0 : active;

  // output off leaves contact open whatever the polarity
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      closed_out <= 1'b0;
    end else begin
      closed_out <= (func_in == CIO_OUT_OFF) ? 1'b0 :
        (raw ^ polarity_in);
    end
  end
endmodule : cio_out_drive

// file: logic/cio_config_store.sv
// Purpose: holds and checks contact io settings, drives contact outputs
// Assumes: contact pins are asynchronous, write requests are on clk_in
// Notes: a refused write leaves every setting unchanged
`timescale 1ns/10ps
module cio_config_store
  import cio_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wr_in,
  input wire logic [3:0] wr_item_in,
  input wire logic [1:0] wr_index_in,
  input wire logic [8:0] wr_value_in,
  input wire logic serial_protocol2_in,
  input wire logic [1:0] contact_in,
  input wire logic [14:0] status_in,
  input wire logic [6:0] alarm_active_in,
  output logic wr_done_out,
  output logic wr_refused_out,
  output logic [1:0] mode_out,
  output logic [2:0] in1_func_out,
  output logic [2:0] in2_func_out,
  output logic [1:0] in_type_out,
  output logic [1:0] in_type_shown_out,
  output logic [1:0] timers_shown_out,
  output logic [17:0] in_delay_out,
  output logic [7:0] in_offdet_out,
  output logic [11:0] out_func_out,
  output logic [2:0] out_pol_out,
  output logic [20:0] out_alarm_out,
  output logic [2:0] out_alarm_shown_out,
  output logic run_request_out,
  output logic [1:0] contact_state_out,
  output logic [2:0] contact_closed_out
);

  function automatic logic is_switch(input logic [2:0] f);
    is_switch = (f == CIO_IN_EXT_SWITCH_NORMALLY_OPEN) ||
      (f == CIO_IN_EXT_SWITCH_NORMALLY_CLOSED);
  endfunction : is_switch

  cio_mode_type mode;
  logic [2:0] in_func [2];
  logic [1:0] in_type;
  logic [8:0] in_delay [2];
  logic [3:0] in_offdet [2];
  logic [3:0] out_func [3];
  logic [2:0] out_pol;
  logic [6:0] out_alarm [3];
  logic [1:0] sync1;
  logic [1:0] sync2;

  wire logic idx0;
  wire logic [1:0] idx;
  wire logic [2:0] new_func;
  wire logic [2:0] cur_func;
  wire logic ok_mode;
  wire logic ok_in_func;
  wire logic ok_type;
  wire logic ok_timer;
  wire logic ok_out;
  wire logic ok_index;
  logic ok;
  wire logic run_level;

  assign idx = wr_index_in;
  assign idx0 = wr_index_in[0];
  assign new_func = wr_value_in[2:0];
  assign cur_func = in_func[idx0];
  assign ok_index = (wr_item_in <= CIO_ITEM_IN_OFFDET) ?
    (idx <= 2'h1) : (idx <= 2'h2);

  assign ok_mode = (wr_value_in[8:2] == 7'h00) &&
    ((wr_value_in[1:0] == CIO_LOCAL_MODE) ||
    ((wr_value_in[1:0] == CIO_DISCRETE_CONTACT_MODE) &&
     !is_switch(in_func[0])) ||
    ((wr_value_in[1:0] == CIO_SERIAL_MODE) &&
     !(serial_protocol2_in && (is_switch(in_func[0]) ||
       in_func[1] == CIO_IN_REMOTE))));

  assign ok_in_func = (wr_value_in <= 9'h004) &&
    !(idx0 == 1'b0 && new_func == CIO_IN_REMOTE) &&
    !(idx0 == 1'b0 && is_switch(new_func) &&
      mode == CIO_DISCRETE_CONTACT_MODE) &&
    !(idx0 == 1'b0 && is_switch(new_func) &&
      mode == CIO_SERIAL_MODE && serial_protocol2_in) &&
    !(idx0 == 1'b1 && new_func == CIO_IN_REMOTE &&
      serial_protocol2_in) &&
    !(in_type[idx0] == CIO_TYPE_MOMENTARY &&
      new_func != CIO_IN_RUN_STOP && new_func != CIO_IN_REMOTE);

  assign ok_type = (cur_func != CIO_IN_OFF) &&
    (wr_value_in <= 9'h001) &&
    (wr_value_in[0] == CIO_TYPE_ALTERNATE ||
     cur_func == CIO_IN_RUN_STOP ||
     (idx0 == 1'b1 && cur_func == CIO_IN_REMOTE));

  assign ok_timer = is_switch(cur_func) &&
    ((wr_item_in == CIO_ITEM_IN_DELAY) ? (wr_value_in <= CIO_DELAY_MAX) :
     (wr_value_in <= {5'h00, CIO_OFFDET_MAX}));

  assign ok_out = (wr_item_in == CIO_ITEM_OUT_FUNC) ?
    (wr_value_in <= {5'h00, CIO_OUT_FUNC_MAX}) :
    (wr_item_in == CIO_ITEM_OUT_POL) ? (wr_value_in <= 9'h001) :
    (out_func[idx] == CIO_OUT_SELECTED_ALARM) &&
    (wr_value_in <= 9'h07F);

  always_comb begin
    ok = 1'b0;
    case (wr_item_in)
      CIO_ITEM_MODE: ok = ok_mode;
      CIO_ITEM_IN_FUNC: ok = ok_index && ok_in_func;
      CIO_ITEM_IN_TYPE: ok = ok_index && ok_type;
      CIO_ITEM_IN_DELAY, CIO_ITEM_IN_OFFDET: ok = ok_index && ok_timer;
      CIO_ITEM_OUT_FUNC, CIO_ITEM_OUT_POL, CIO_ITEM_OUT_ALARM:
        ok = ok_index && ok_out;
      default: ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode <= CIO_LOCAL_MODE;
      in_func[0] <= CIO_IN1_FUNC_RESET;
      in_func[1] <= CIO_IN2_FUNC_RESET;
      in_type <= {2{CIO_TYPE_ALTERNATE}};
      for (int i = 0; i < 2; i++) begin
        in_delay[i] <= CIO_DELAY_RESET;
        in_offdet[i] <= CIO_OFFDET_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        out_func[i] <= CIO_OUT_FUNC_RESET[4*i +: 4];
        out_alarm[i] <= CIO_ALARM_RESET;
      end
      out_pol <= CIO_POL_RESET;
      wr_done_out <= 1'b0;
      wr_refused_out <= 1'b0;
    end else begin
      wr_done_out <= wr_in && ok;
      wr_refused_out <= wr_in && !ok;
      if (wr_in && ok) begin
        case (wr_item_in)
          CIO_ITEM_MODE: mode <= cio_mode_type'(wr_value_in[1:0]);
          CIO_ITEM_IN_FUNC: in_func[idx0] <= new_func;
          CIO_ITEM_IN_TYPE: in_type[idx0] <= wr_value_in[0];
          CIO_ITEM_IN_DELAY: in_delay[idx0] <= wr_value_in;
          CIO_ITEM_IN_OFFDET: in_offdet[idx0] <= wr_value_in[3:0];
          CIO_ITEM_OUT_FUNC: out_func[idx] <= wr_value_in[3:0];
          CIO_ITEM_OUT_POL: out_pol[idx] <= wr_value_in[0];
          CIO_ITEM_OUT_ALARM: out_alarm[idx] <= wr_value_in[6:0];
          default: mode <= mode;
        endcase
      end
    end
  end

  // contact pins through two flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= contact_in;
      sync2 <= sync1;
    end
  end

  // run level comes from any input set to run/stop, alternate or momentary type alike
  assign run_level = (in_func[0] == CIO_IN_RUN_STOP && sync2[0]) ||
    (in_func[1] == CIO_IN_RUN_STOP && sync2[1]);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_request_out <= 1'b0;
      contact_state_out <= 2'h0;
    end else begin
      contact_state_out <= sync2;
      // no edge needed: a held run input starts once mode is discrete
      run_request_out <= (mode == CIO_DISCRETE_CONTACT_MODE) &&
        run_level;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_out <= CIO_MODE_RESET;
      in1_func_out <= CIO_IN1_FUNC_RESET;
      in2_func_out <= CIO_IN2_FUNC_RESET;
      in_type_out <= 2'h0;
      in_type_shown_out <= 2'h1;
      timers_shown_out <= 2'h0;
      in_delay_out <= 18'h00000;
      in_offdet_out <= 8'h00;
      out_func_out <= CIO_OUT_FUNC_RESET;
      out_pol_out <= CIO_POL_RESET;
      out_alarm_out <= {3{CIO_ALARM_RESET}};
      out_alarm_shown_out <= 3'h0;
    end else begin
      mode_out <= mode;
      in1_func_out <= in_func[0];
      in2_func_out <= in_func[1];
      in_type_out <= in_type;
      in_type_shown_out <= {in_func[1] != CIO_IN_OFF,
        in_func[0] != CIO_IN_OFF};
      timers_shown_out <= {is_switch(in_func[1]),
        is_switch(in_func[0])};
      in_delay_out <= {in_delay[1], in_delay[0]};
      in_offdet_out <= {in_offdet[1], in_offdet[0]};
      out_func_out <= {out_func[2], out_func[1], out_func[0]};
      out_pol_out <= out_pol;
      out_alarm_out <= {out_alarm[2], out_alarm[1], out_alarm[0]};
      out_alarm_shown_out <= {out_func[2] == CIO_OUT_SELECTED_ALARM,
        out_func[1] == CIO_OUT_SELECTED_ALARM,
        out_func[0] == CIO_OUT_SELECTED_ALARM};
    end
  end

  for (genvar g = 0; g < 3; g++) begin : gen_out
    cio_out_drive u_drive (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .func_in(out_func[g]),
      .polarity_in(out_pol[g]),
      .alarm_sel_in(out_alarm[g]),
      .status_in(status_in),
      .alarm_active_in(alarm_active_in),
      .closed_out(contact_closed_out[g])
    );
  end

endmodule : cio_config_store

// file: verification/cio_chk.sv
// Purpose: port assertions for the contact io configuration store
// Assumes: one clock, asynchronous active low reset
// Notes: contact check skips cycles where settings just moved
`timescale 1ns/10ps
module cio_chk
  import cio_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wr_in,
  input wire logic [14:0] status_in,
  input wire logic wr_done_out,
  input wire logic wr_refused_out,
  input wire logic [1:0] mode_out,
  input wire logic [2:0] in1_func_out,
  input wire logic [1:0] in_type_out,
  input wire logic [1:0] in_type_shown_out,
  input wire logic [1:0] timers_shown_out,
  input wire logic [11:0] out_func_out,
  input wire logic [2:0] out_pol_out,
  input wire logic [2:0] out_alarm_shown_out,
  input wire logic run_request_out,
  input wire logic [2:0] contact_closed_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic exp_closed;
  wire logic [3:0] func0 = out_func_out[3:0];
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      exp_closed <= 1'h0;
    end else begin
      exp_closed <= (func0 != CIO_OUT_OFF) &&
        (status_in[func0] ^ out_pol_out[0]);
    end
  end
  sequence answer_s;
    wr_done_out ^ wr_refused_out;
  endsequence
  sequence settled_s;
    $stable(out_func_out) && $stable(out_pol_out);
  endsequence
  answer_a: assert property (wr_in |=> answer_s)
    else $error("write got no single answer");
  keep_a: assert property (wr_refused_out |=> $stable(mode_out) &&
    $stable(in1_func_out) && $stable(out_pol_out))
    else $error("refused write changed a setting");
  mode_legal_a: assert property (mode_out != 2'h3)
    else $error("mode out of range");
  discrete_in1_a: assert property (mode_out == 2'h1 |->
    !in1_func_out[1])
    else $error("switch input in discrete mode");
  type_shown_a: assert property (
    in_type_shown_out[0] == (in1_func_out != 3'h0))
    else $error("input type visibility wrong");
  timers_a: assert property (
    timers_shown_out[0] == (in1_func_out[2:1] == 2'h1))
    else $error("timer visibility wrong");
  momentary_a: assert property (in_type_out[0] |->
    in1_func_out == 3'h1)
    else $error("momentary without run input");
  alarm_shown_a: assert property (
    out_alarm_shown_out[0] == (func0 == 4'h7))
    else $error("alarm visibility wrong");
  contact_a: assert property (settled_s and func0 != 4'h7 |->
    contact_closed_out[0] == exp_closed)
    else $error("contact level wrong");
  run_a: assert property (run_request_out |->
    mode_out == 2'h1 || $past(mode_out) == 2'h1)
    else $error("run outside discrete mode");
endmodule : cio_chk
bind cio_config_store cio_chk i_chk (.clk_in, .reset_n_in, .wr_in, .status_in,
  .wr_done_out, .wr_refused_out, .mode_out, .in1_func_out, .in_type_out,
  .in_type_shown_out, .timers_shown_out, .out_func_out, .out_pol_out,
  .out_alarm_shown_out, .run_request_out, .contact_closed_out);

// file: verification/cio_contact_model.sv
// Purpose: customer wiring driving the two contact inputs
// Assumes: pins move with no relation to the clock
// Notes: run level is set before discrete mode is chosen
`timescale 1ns/10ps
module cio_contact_model (
  input wire logic [1:0] level_in,
  input wire logic [2:0] closed_in,
  output logic [1:0] contact_out
);
  initial contact_out = 2'h0;
  // wiring skew keeps pin edges off the clock edge
  always @(level_in) contact_out <= #3 level_in;
endmodule : cio_contact_model

// file: verification/cio_config_store_tb.sv
// Purpose: self-checking bench for the contact io configuration store
// Assumes: inputs driven at the falling edge, one write per two cycles
// Notes: expected values come from bench functions and tracking
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t got %h want %h", $time, a, b); end end
module cio_config_store_tb
  import cio_pkg::*;
;
  logic clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic wr_in = 1'h0;
  logic [3:0] wr_item_in = 4'h0;
  logic [1:0] wr_index_in = 2'h0;
  logic [8:0] wr_value_in = 9'h000;
  logic serial_protocol2_in = 1'h0;
  logic [1:0] pin_level = 2'h0;
  logic [1:0] contact_in;
  logic [14:0] status_in = 15'h0000;
  logic [6:0] alarm_active_in = 7'h00;
  logic wr_done_out, wr_refused_out, run_request_out;
  logic [1:0] mode_out, in_type_out, in_type_shown_out, timers_shown_out;
  logic [1:0] contact_state_out;
  logic [2:0] in1_func_out, in2_func_out, out_pol_out, out_alarm_shown_out;
  logic [2:0] contact_closed_out;
  logic [17:0] in_delay_out;
  logic [7:0] in_offdet_out;
  logic [11:0] out_func_out;
  logic [20:0] out_alarm_out;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h6B3C;
  logic [2:0] pol_exp = 3'h4;
  logic [3:0] func_exp = 4'h7;
  logic [3:0] func_try = 4'h0;
  logic [2:0] cl_exp = 3'h0;
  always #4 clk_in = ~clk_in;
  cio_config_store i_dut (.clk_in, .reset_n_in, .wr_in, .wr_item_in,
    .wr_index_in, .wr_value_in, .serial_protocol2_in, .contact_in, .status_in,
    .alarm_active_in, .wr_done_out, .wr_refused_out, .mode_out, .in1_func_out,
    .in2_func_out, .in_type_out, .in_type_shown_out, .timers_shown_out,
    .in_delay_out, .in_offdet_out, .out_func_out, .out_pol_out, .out_alarm_out,
    .out_alarm_shown_out, .run_request_out, .contact_state_out,
    .contact_closed_out);
  cio_contact_model i_wire (.level_in(pin_level),
    .closed_in(contact_closed_out), .contact_out(contact_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic closed_exp(input logic [3:0] f, input logic p,
      input logic [14:0] s);
    return (f != CIO_OUT_OFF) && (s[f] ^ p);
  endfunction : closed_exp
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [3:0] item, input int idx,
      input logic [8:0] val, input logic ok);
    wr_item_in = item;
    wr_index_in = 2'(idx);
    wr_value_in = val;
    wr_in = 1'h1;
    @(negedge clk_in);
    wr_in = 1'h0;
    `CHK({wr_done_out, wr_refused_out}, {ok, ~ok})
    @(negedge clk_in);
  endtask : wr
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'h1;
    `CHK({mode_out, in1_func_out, in2_func_out}, 8'h08)
    `CHK({in_type_out, in_type_shown_out, timers_shown_out}, 6'h04)
    `CHK({in_delay_out, in_offdet_out}, 26'h0)
    `CHK({out_func_out, out_pol_out}, 15'h310C)
    `CHK({out_alarm_out, out_alarm_shown_out}, {{3{7'h01}}, 3'h0})
    wr(CIO_ITEM_IN_TYPE, 0, 9'h1, 1'h1);
    `CHK(contact_closed_out, 3'h4)
    wr(CIO_ITEM_IN_FUNC, 0, 9'h2, 1'h0);
    wr(CIO_ITEM_IN_TYPE, 0, 9'h0, 1'h1);
    wr(CIO_ITEM_IN_FUNC, 0, 9'h2, 1'h1);
    wr(CIO_ITEM_IN_DELAY, 0, 9'h12C, 1'h1);
    wr(CIO_ITEM_IN_DELAY, 0, 9'h12D, 1'h0);
    wr(CIO_ITEM_IN_OFFDET, 0, 9'hA, 1'h1);
    wr(CIO_ITEM_IN_OFFDET, 0, 9'hB, 1'h0);
    `CHK({in_delay_out, in_offdet_out}, 26'h12C0A)
    wr(CIO_ITEM_MODE, 0, 9'h1, 1'h0);
    serial_protocol2_in = 1'h1;
    wr(CIO_ITEM_MODE, 0, 9'h2, 1'h0);
    wr(CIO_ITEM_IN_FUNC, 0, 9'h1, 1'h1);
    wr(CIO_ITEM_IN_TYPE, 1, 9'h1, 1'h0);
    wr(CIO_ITEM_MODE, 0, 9'h2, 1'h1);
    wr(CIO_ITEM_IN_FUNC, 0, 9'h3, 1'h0);
    serial_protocol2_in = 1'h0;
    wr(CIO_ITEM_IN_FUNC, 1, 9'h4, 1'h1);
    wr(CIO_ITEM_MODE, 0, 9'h0, 1'h1);
    serial_protocol2_in = 1'h1;
    wr(CIO_ITEM_MODE, 0, 9'h2, 1'h0);
    wr(CIO_ITEM_MODE, 0, 9'h3, 1'h0);
    wr(CIO_ITEM_MODE, 0, 9'h5, 1'h0);
    wr(CIO_ITEM_IN_FUNC, 1, 9'h0, 1'h1);
    `CHK({mode_out, in2_func_out}, 5'h00)
    $display("test inputs finished");
    pin_level = 2'h1;
    repeat (4) @(negedge clk_in);
    `CHK({run_request_out, contact_state_out}, 3'h1)
    wr(CIO_ITEM_MODE, 0, 9'h1, 1'h1);
    @(negedge clk_in);
    `CHK({run_request_out, contact_state_out}, 3'h5)
    wr(CIO_ITEM_IN_FUNC, 0, 9'h2, 1'h0);
    pin_level = 2'h0;
    repeat (4) @(negedge clk_in);
    `CHK({run_request_out, contact_state_out}, 3'h0)
    wr(CIO_ITEM_MODE, 0, 9'h0, 1'h1);
    $display("test discrete finished");
    wr(CIO_ITEM_OUT_ALARM, 0, 9'h5, 1'h0);
    wr(CIO_ITEM_OUT_FUNC, 0, 9'h7, 1'h1);
    wr(CIO_ITEM_OUT_ALARM, 0, 9'h5, 1'h1);
    `CHK({out_alarm_out[6:0], out_alarm_shown_out}, 10'h029)
    alarm_active_in = 7'h05;
    @(negedge clk_in);
    `CHK(contact_closed_out, 3'h5)
    alarm_active_in = 7'h06;
    @(negedge clk_in);
    `CHK(contact_closed_out[0], 1'h0)
    wr(CIO_ITEM_OUT_FUNC, 0, 9'hF, 1'h0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      status_in = seed[22:8];
      wr(CIO_ITEM_OUT_POL, int'(seed[1:0]), {8'h0, seed[2]},
        seed[1:0] != 2'h3);
      if (seed[1:0] != 2'h3) pol_exp[seed[1:0]] = seed[2];
      func_try = (seed[6:3] == 4'h7) ? 4'h6 : seed[6:3];
      wr(CIO_ITEM_OUT_FUNC, 0, {5'h0, func_try}, func_try != 4'hF);
      if (func_try != 4'hF) func_exp = func_try;
      @(negedge clk_in);
      cl_exp = {closed_exp(CIO_OUT_ALARM_STATE, pol_exp[2], status_in),
        closed_exp(CIO_OUT_REMOTE_STATE, pol_exp[1], status_in),
        closed_exp(func_exp, pol_exp[0], status_in)};
      `CHK(out_pol_out, pol_exp)
      `CHK(contact_closed_out, cl_exp)
    end
    $display("test outputs finished");
    give_verdict();
  end
endmodule : cio_config_store_tb
